// >>> common/cse_pkg.sv
package cse_pkg;
  localparam int unsigned CSE_ADDR_W = 8;
  localparam logic [7:0] CSE_OFF_CTRL = 8'h00;
  localparam logic [7:0] CSE_OFF_STATUS = 8'h04;
  localparam logic [7:0] CSE_OFF_PC_LO = 8'h08;
  localparam logic [7:0] CSE_OFF_PC_HI = 8'h0C;
  localparam logic [7:0] CSE_OFF_RST_LO = 8'h10;
  localparam logic [7:0] CSE_OFF_RST_HI = 8'h14;
  localparam int unsigned CSE_CTRL_SWAP_BIT = 0;
  localparam int unsigned CSE_ST_CFG_BIT = 0;
  localparam int unsigned CSE_ST_LSO_BIT = 1;
  localparam int unsigned CSE_ST_LLF_BIT = 2;
  localparam int unsigned CSE_ST_ISA_BIT = 3;
  localparam int unsigned CSE_ST_SWAP_BIT = 4;
  localparam logic CSE_ORDER_LITTLE = 1'b0;
  localparam logic CSE_ORDER_BIG = 1'b1;
  localparam logic CSE_ISA_STD = 1'b0;
  localparam logic CSE_ISA_CMP = 1'b1;
  localparam logic [63:0] CSE_INC_STD = 64'h0000_0000_0000_0004;
  localparam logic [63:0] CSE_INC_CMP = 64'h0000_0000_0000_0002;
  localparam logic [63:0] CSE_LINK_STD = 64'h0000_0000_0000_0008;
  localparam logic [63:0] CSE_LINK_CMP = 64'h0000_0000_0000_0004;
  localparam logic [63:0] CSE_PC_RESET = 64'hFFFF_FFFF_BFC0_0000;
  localparam logic [31:0] CSE_CTRL_RESET = 32'h0000_0000;
  typedef enum logic [1:0] {
    CSE_ST_SEQ = 2'b01,
    CSE_ST_DELAY = 2'b10
  } cse_slot_t;
endpackage

// >>> design/cse_core_seq.sv
// The APB slave port and the register offsets were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module cse_core_seq
  import cse_pkg::*;
#(
  parameter logic [63:0] PC_RESET = CSE_PC_RESET
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic byte_order_strap,
  input wire logic user_mode,
  input wire logic slot_valid,
  input wire logic instr_compressed,
  input wire logic pc_assign,
  input wire logic [63:0] pc_assign_value,
  input wire logic pc_assign_isa,
  input wire logic branch_taken,
  input wire logic [63:0] branch_target,
  input wire logic link_req,
  input wire logic [4:0] link_idx,
  input wire logic exc_req,
  input wire logic [63:0] exc_vector,
  input wire logic imm_req,
  input wire logic [4:0] imm_idx,
  input wire logic [63:0] imm_data,
  input wire logic dly_req,
  input wire logic [4:0] dly_idx,
  input wire logic [63:0] dly_data,
  input wire logic ll_access,
  input wire logic sc_access,
  input wire logic store_conflict,
  input wire logic eret,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [63:0] pc,
  output logic instr_set_selector,
  output logic reset_byte_order_cfg,
  output logic mem_byte_order,
  output logic load_store_byte_order,
  output logic user_endian_swap,
  output logic link_reservation_flag,
  output logic sc_done,
  output logic sc_success,
  output logic wb_now_valid,
  output logic [4:0] wb_now_idx,
  output logic [63:0] wb_now_data,
  output logic wb_late_valid,
  output logic [4:0] wb_late_idx,
  output logic [63:0] wb_late_data,
  output logic exc_valid,
  output logic [63:0] exc_restart
);
  cse_slot_t state;
  cse_slot_t next_state;
  logic strap_done;
  logic [31:0] ctrl;
  logic [63:0] br_target;
  logic [63:0] next_pc;
  logic next_isa;
  logic next_llf;
  logic late_pend;
  logic [4:0] late_idx;
  logic [63:0] late_data;
  logic [63:0] restart_last;
  logic [31:0] next_prdata;

  // strap caught by a clocked process after release, never by the reset
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      strap_done <= 1'b0;
      reset_byte_order_cfg <= CSE_ORDER_LITTLE;
    end else if (!strap_done) begin
      strap_done <= 1'b1;
      reset_byte_order_cfg <= byte_order_strap;
    end
  end

  wire swap_en = ctrl[CSE_CTRL_SWAP_BIT];
  assign user_endian_swap = swap_en & user_mode;
  assign mem_byte_order = reset_byte_order_cfg;
  // kernel and supervisor never see the swap, since it needs user mode
  assign load_store_byte_order = reset_byte_order_cfg ^ user_endian_swap;

  // pc sequencing; exception outranks the delay-slot redirect
  wire [63:0] pc_step = instr_compressed ? CSE_INC_CMP : CSE_INC_STD;
  wire [63:0] link_step = instr_compressed ? CSE_LINK_CMP : CSE_LINK_STD;
  wire [63:0] link_addr = pc + link_step;
  wire [63:0] seq_pc = pc + pc_step;

  always_comb begin
    next_state = state;
    next_pc = pc;
    next_isa = instr_set_selector;
    if (slot_valid) begin
      case (state)
        CSE_ST_SEQ: begin
          next_pc = pc_assign ? pc_assign_value : seq_pc;
          if (pc_assign) begin
            next_isa = pc_assign_isa;
          end
          if (branch_taken) begin
            next_state = CSE_ST_DELAY;
          end
        end
        CSE_ST_DELAY: begin
          next_pc = br_target;
          next_state = CSE_ST_SEQ;
        end
        default: begin
          next_state = CSE_ST_SEQ;
        end
      endcase
      if (exc_req) begin
        next_pc = exc_vector;
        next_state = CSE_ST_SEQ;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= CSE_ST_SEQ;
      pc <= PC_RESET;
      instr_set_selector <= CSE_ISA_STD;
      br_target <= '0;
    end else begin
      state <= next_state;
      pc <= next_pc;
      instr_set_selector <= next_isa;
      if (slot_valid && branch_taken && state == CSE_ST_SEQ) begin
        br_target <= branch_target;
      end
    end
  end

  // set wins over clear in the same slot
  always_comb begin
    next_llf = link_reservation_flag;
    if (slot_valid && (store_conflict || eret)) begin
      next_llf = 1'b0;
    end
    if (slot_valid && ll_access) begin
      next_llf = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      link_reservation_flag <= 1'b0;
      sc_done <= 1'b0;
      sc_success <= 1'b0;
    end else begin
      link_reservation_flag <= next_llf;
      sc_done <= slot_valid & sc_access;
      sc_success <= slot_valid & sc_access & link_reservation_flag;
    end
  end

  // write-back: own-slot effects and the previous slot's deferred ones
  // appear in the same cycle; their relative order is left open
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wb_now_valid <= 1'b0;
      wb_now_idx <= '0;
      wb_now_data <= '0;
      wb_late_valid <= 1'b0;
      wb_late_idx <= '0;
      wb_late_data <= '0;
      late_pend <= 1'b0;
      late_idx <= '0;
      late_data <= '0;
      exc_valid <= 1'b0;
      exc_restart <= '0;
      restart_last <= '0;
    end else begin
      wb_now_valid <= slot_valid & (imm_req | link_req);
      wb_late_valid <= slot_valid & late_pend;
      exc_valid <= slot_valid & exc_req;
      if (slot_valid) begin
        if (link_req) begin
          wb_now_idx <= link_idx;
          wb_now_data <= {link_addr[63:1], instr_set_selector};
          restart_last <= {link_addr[63:1], instr_set_selector};
        end else if (imm_req) begin
          wb_now_idx <= imm_idx;
          wb_now_data <= imm_data;
        end
        wb_late_idx <= late_idx;
        wb_late_data <= late_data;
        late_pend <= dly_req;
        late_idx <= dly_idx;
        late_data <= dly_data;
        if (exc_req) begin
          exc_restart <= {pc[63:1], instr_set_selector};
          restart_last <= {pc[63:1], instr_set_selector};
        end
      end
    end
  end

  // apb: read data latched in setup so access always completes at once
  wire apb_setup = psel & ~penable;
  wire apb_access = psel & penable;
  wire hit_ctrl = paddr == CSE_OFF_CTRL;
  wire hit_stat = paddr == CSE_OFF_STATUS;
  wire hit_pclo = paddr == CSE_OFF_PC_LO;
  wire hit_pchi = paddr == CSE_OFF_PC_HI;
  wire hit_rslo = paddr == CSE_OFF_RST_LO;
  wire hit_rshi = paddr == CSE_OFF_RST_HI;
  wire hit_any = hit_ctrl | hit_stat | hit_pclo | hit_pchi | hit_rslo |
    hit_rshi;
  wire [31:0] stat_word = {27'h0, user_endian_swap, instr_set_selector,
    link_reservation_flag, load_store_byte_order, reset_byte_order_cfg};

  always_comb begin
    next_prdata = 32'h0000_0000;
    if (hit_ctrl) next_prdata = ctrl;
    if (hit_stat) next_prdata = stat_word;
    if (hit_pclo) next_prdata = pc[31:0];
    if (hit_pchi) next_prdata = pc[63:32];
    if (hit_rslo) next_prdata = restart_last[31:0];
    if (hit_rshi) next_prdata = restart_last[63:32];
  end

  assign pready = 1'b1;
  assign pslverr = apb_access & ~hit_any;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prdata <= 32'h0000_0000;
      ctrl <= CSE_CTRL_RESET;
    end else begin
      if (apb_setup && !pwrite) prdata <= next_prdata;
      if (apb_access && pwrite && hit_ctrl) begin
        ctrl <= {31'h0, pwdata[CSE_CTRL_SWAP_BIT]};
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  // checker shadow of a pending branch and a deferred write, kept apart
  // from the datapath so that the properties do not restate it
  logic chk_br_pend;
  logic [63:0] chk_br_tgt;
  logic chk_dly_pend;
  logic [4:0] chk_dly_idx;
  logic [63:0] chk_dly_data;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      chk_br_pend <= 1'b0;
      chk_br_tgt <= '0;
      chk_dly_pend <= 1'b0;
      chk_dly_idx <= '0;
      chk_dly_data <= '0;
    end else if (slot_valid) begin
      chk_br_pend <= branch_taken & ~exc_req & ~chk_br_pend;
      if (branch_taken && !chk_br_pend) begin
        chk_br_tgt <= branch_target;
      end
      chk_dly_pend <= dly_req;
      chk_dly_idx <= dly_idx;
      chk_dly_data <= dly_data;
    end
  end

  sequence s_br_taken;
    slot_valid && branch_taken && !exc_req && !chk_br_pend;
  endsequence
  sequence s_ds_slot;
    slot_valid && !exc_req && chk_br_pend;
  endsequence

  property p_cfg_hold;
    strap_done |=> $stable(reset_byte_order_cfg);
  endproperty
  a_cfg_hold: assert property (p_cfg_hold)
    else $error("byte order changed after capture");
  property p_kernel_order;
    !user_mode |-> load_store_byte_order == mem_byte_order;
  endproperty
  a_kernel_order: assert property (p_kernel_order)
    else $error("kernel byte order differs from strap");
  property p_ls_order;
    load_store_byte_order == (reset_byte_order_cfg ^ (swap_en & user_mode));
  endproperty
  a_ls_order: assert property (p_ls_order)
    else $error("load store byte order wrong");
  property p_swap_user;
    user_endian_swap |-> user_mode && ctrl[CSE_CTRL_SWAP_BIT];
  endproperty
  a_swap_user: assert property (p_swap_user)
    else $error("swap outside user mode");
  property p_ll_set;
    slot_valid && ll_access |=> link_reservation_flag;
  endproperty
  a_ll_set: assert property (p_ll_set)
    else $error("reservation not set");
  property p_ll_clr;
    slot_valid && (eret || store_conflict) && !ll_access
      |=> !link_reservation_flag;
  endproperty
  a_ll_clr: assert property (p_ll_clr)
    else $error("reservation not cleared");
  property p_imm_wb;
    slot_valid && imm_req && !link_req
      |=> wb_now_valid && wb_now_idx == $past(imm_idx);
  endproperty
  a_imm_wb: assert property (p_imm_wb)
    else $error("own slot write missing");
  property p_late_wb;
    slot_valid && chk_dly_pend |=> wb_late_valid &&
      wb_late_idx == $past(chk_dly_idx) &&
      wb_late_data == $past(chk_dly_data);
  endproperty
  a_late_wb: assert property (p_late_wb)
    else $error("deferred write not with next slot");
  property p_pc_idle;
    !slot_valid |=> $stable(pc);
  endproperty
  a_pc_idle: assert property (p_pc_idle)
    else $error("pc moved without a slot");
  property p_pc_step;
    slot_valid && state == CSE_ST_SEQ && !pc_assign && !exc_req
      |=> pc == $past(pc) + (($past(instr_compressed)) ? CSE_INC_CMP
        : CSE_INC_STD);
  endproperty
  a_pc_step: assert property (p_pc_step)
    else $error("pc step wrong");
  property p_branch;
    s_ds_slot |=> pc == $past(chk_br_tgt) && state == CSE_ST_SEQ;
  endproperty
  a_branch: assert property (p_branch)
    else $error("branch target not taken in delay slot");
  property p_br_enter;
    s_br_taken |=> state == CSE_ST_DELAY;
  endproperty
  a_br_enter: assert property (p_br_enter)
    else $error("taken branch did not open a delay slot");
  property p_exc_restart;
    slot_valid && exc_req |=> exc_valid &&
      exc_restart == {$past(pc[63:1]), $past(instr_set_selector)};
  endproperty
  a_exc_restart: assert property (p_exc_restart)
    else $error("exception restart address wrong");
  property p_pc_assign;
    slot_valid && pc_assign && !exc_req && state == CSE_ST_SEQ
      |=> pc == $past(pc_assign_value) &&
        instr_set_selector == $past(pc_assign_isa);
  endproperty
  a_pc_assign: assert property (p_pc_assign)
    else $error("pc assignment lost bits");
endmodule // cse_core_seq
`default_nettype wire

// >>> design/README_unused.sv
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

// >>> tb/cse_core_seq_tb.sv
`timescale 1ns/100ps
`default_nettype none
module cse_core_seq_tb
  import cse_pkg::*;
;
  logic clk, reset_n, byte_order_strap, user_mode, slot_valid;
  logic instr_compressed, pc_assign, pc_assign_isa, branch_taken;
  logic link_req, exc_req, imm_req, dly_req, ll_access, sc_access;
  logic store_conflict, eret, psel, penable, pwrite, pready, pslverr;
  logic [63:0] pc_assign_value, branch_target, exc_vector, imm_data;
  logic [63:0] dly_data, pc, wb_now_data, wb_late_data, exc_restart;
  logic [4:0] link_idx, imm_idx, dly_idx, wb_now_idx, wb_late_idx;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic instr_set_selector, reset_byte_order_cfg, mem_byte_order;
  logic load_store_byte_order, user_endian_swap, link_reservation_flag;
  logic sc_done, sc_success, wb_now_valid, wb_late_valid, exc_valid, err;
  int fail_count = 0;
  int checks_done = 0;
  int cycles = 0;
  localparam logic [11:0] F_ISA = 12'h800, F_CMP = 12'h400;
  localparam logic [11:0] F_ASG = 12'h200, F_BR = 12'h100;
  localparam logic [11:0] F_LNK = 12'h080, F_EXC = 12'h040;
  localparam logic [11:0] F_IMM = 12'h020, F_DLY = 12'h010;
  localparam logic [11:0] F_LL = 12'h008, F_SC = 12'h004;
  localparam logic [11:0] F_CF = 12'h002, F_ER = 12'h001;

  cse_core_seq dut_u (.clk, .reset_n, .byte_order_strap, .user_mode,
    .slot_valid, .instr_compressed, .pc_assign, .pc_assign_value,
    .pc_assign_isa, .branch_taken, .branch_target, .link_req, .link_idx,
    .exc_req, .exc_vector, .imm_req, .imm_idx, .imm_data, .dly_req,
    .dly_idx, .dly_data, .ll_access, .sc_access, .store_conflict, .eret,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .pc, .instr_set_selector, .reset_byte_order_cfg, .mem_byte_order,
    .load_store_byte_order, .user_endian_swap, .link_reservation_flag,
    .sc_done, .sc_success, .wb_now_valid, .wb_now_idx, .wb_now_data,
    .wb_late_valid, .wb_late_idx, .wb_late_data, .exc_valid, .exc_restart);

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input string n, input logic [63:0] e, g);
    checks_done++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", n, e, g);
      fail_count++;
    end
  endtask

  // flags linger after the slot; slot_valid low makes them inert
  task automatic slot(input logic [11:0] f, input logic [63:0] d);
    @(posedge clk);
    slot_valid <= 1'h1;
    {pc_assign_isa, instr_compressed, pc_assign, branch_taken, link_req,
     exc_req, imm_req, dly_req, ll_access, sc_access, store_conflict,
     eret} <= f;
    {pc_assign_value, branch_target, exc_vector, imm_data} <= {4{d}};
    dly_data <= d;
    {link_idx, imm_idx, dly_idx} <= {3{d[4:0]}};
    @(posedge clk);
    slot_valid <= 1'h0;
    #1;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'h1, 1'h0, w, a, d};
    @(posedge clk);
    penable <= 1'h1;
    do @(posedge clk); while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'h0;
  endtask

  task automatic do_reset(input logic s);
    @(posedge clk);
    reset_n <= 1'h0;
    byte_order_strap <= s;
    repeat (2) @(posedge clk);
    reset_n <= 1'h1;
    repeat (2) @(posedge clk);
    #1;
    chk("cfg", s, reset_byte_order_cfg);
    chk("mem_order", s, mem_byte_order);
    chk("pc_reset", CSE_PC_RESET, pc);
  endtask

  task automatic t_endian();
    @(posedge clk);
    byte_order_strap <= 1'h0;
    user_mode <= 1'h0;
    apb(1'h1, CSE_OFF_CTRL, 32'h0000_0001);
    #1;
    chk("swap_kernel", 1'h0, user_endian_swap);
    chk("ls_kernel", 1'h1, load_store_byte_order);
    @(posedge clk);
    user_mode <= 1'h1;
    apb(1'h0, CSE_OFF_STATUS, 32'h0);
    chk("status", 32'h0000_0011, rd);
    chk("ls_user", 1'h0, load_store_byte_order);
    chk("cfg_held", 1'h1, reset_byte_order_cfg);
    apb(1'h0, 8'h40, 32'h0);
    chk("unmapped_err", 1'h1, err);
    chk("unmapped_data", 32'h0, rd);
  endtask

  // swap enable clears on reset, so user mode alone must not swap
  task automatic t_strap_low();
    do_reset(1'h0);
    chk("swap_cleared", 1'h0, user_endian_swap);
    apb(1'h1, CSE_OFF_CTRL, 32'h0000_0001);
    #1;
    chk("ls_swapped", 1'h1, load_store_byte_order);
  endtask

  task automatic t_pc();
    slot(F_ASG, 64'h1234_5678_FFFF_FFFC);
    chk("pc_assign", 64'h1234_5678_FFFF_FFFC, pc);
    slot(12'h0, 64'h0);
    chk("pc_carry", 64'h1234_5679_0000_0000, pc);
    apb(1'h0, CSE_OFF_PC_HI, 32'h0);
    chk("pc_hi", 32'h1234_5679, rd);
    slot(F_CMP, 64'h0);
    chk("pc_cmp", 64'h1234_5679_0000_0002, pc);
    slot(F_BR, 64'h0000_0000_0000_8000);
    chk("pc_br", 64'h1234_5679_0000_0006, pc);
    slot(F_ASG, 64'h0000_0000_0000_9000);
    chk("pc_delay", 64'h0000_0000_0000_8000, pc);
    slot(F_ASG | F_ISA, 64'h0000_0000_0000_0100);
    chk("isa", CSE_ISA_CMP, instr_set_selector);
    slot(F_LNK | F_CMP, 64'h0000_0000_0000_0005);
    chk("link_data", 64'h0000_0000_0000_0105, wb_now_data);
    chk("link_idx", 5'h05, wb_now_idx);
    chk("pc_cmp2", 64'h0000_0000_0000_0102, pc);
    slot(F_EXC, 64'h0000_0000_0000_0180);
    chk("exc_valid", 1'h1, exc_valid);
    chk("exc_restart", 64'h0000_0000_0000_0103, exc_restart);
    chk("exc_pc", 64'h0000_0000_0000_0180, pc);
    apb(1'h0, CSE_OFF_PC_LO, 32'h0);
    chk("pc_lo", 32'h0000_0180, rd);
    chk("pready", 1'h1, pready);
    apb(1'h0, CSE_OFF_RST_LO, 32'h0);
    chk("rst_lo", 32'h0000_0103, rd);
    apb(1'h0, CSE_OFF_RST_HI, 32'h0);
    chk("rst_hi", 32'h0000_0000, rd);
    slot(F_BR | F_EXC, 64'h0000_0000_0000_0200);
    chk("exc_over_br", 64'h0000_0000_0000_0200, pc);
    slot(12'h0, 64'h0);
    chk("br_cancel", 64'h0000_0000_0000_0204, pc);
  endtask

  task automatic t_wb();
    slot(F_IMM | F_DLY, 64'h0000_0000_0000_00A3);
    chk("now_valid", 1'h1, wb_now_valid);
    chk("now_data", 64'h0000_0000_0000_00A3, wb_now_data);
    chk("late_early", 1'h0, wb_late_valid);
    slot(F_IMM, 64'h0000_0000_0000_00B4);
    chk("late_valid", 1'h1, wb_late_valid);
    chk("late_data", 64'h0000_0000_0000_00A3, wb_late_data);
    chk("late_idx", 5'h03, wb_late_idx);
    chk("now_data2", 64'h0000_0000_0000_00B4, wb_now_data);
  endtask

  task automatic t_ll();
    slot(F_LL, 64'h0);
    chk("flag_set", 1'h1, link_reservation_flag);
    slot(F_SC, 64'h0);
    chk("sc_done", 1'h1, sc_done);
    chk("sc_ok", 1'h1, sc_success);
    slot(F_CF, 64'h0);
    chk("flag_conflict", 1'h0, link_reservation_flag);
    slot(F_SC, 64'h0);
    chk("sc_fail", 1'h0, sc_success);
    slot(F_LL, 64'h0);
    slot(F_ER, 64'h0);
    chk("flag_eret", 1'h0, link_reservation_flag);
    slot(F_LL | F_ER, 64'h0);
    chk("flag_set_wins", 1'h1, link_reservation_flag);
  endtask

  initial begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end

  // whole run is under a hundred cycles; ceiling leaves ample slack
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      fail_count++;
      print_verdict();
    end
  end

  initial begin
    {reset_n, byte_order_strap, user_mode, slot_valid, instr_compressed,
     pc_assign, pc_assign_isa, branch_taken, link_req, exc_req, imm_req,
     dly_req, ll_access, sc_access, store_conflict, eret, psel, penable,
     pwrite} = '0;
    {pc_assign_value, branch_target, exc_vector, imm_data, dly_data} = '0;
    {link_idx, imm_idx, dly_idx, paddr, pwdata} = '0;
    do_reset(1'h1);
    t_endian();
    t_pc();
    t_wb();
    t_ll();
    t_strap_low();
    print_verdict();
  end
endmodule // cse_core_seq_tb
`default_nettype wire
